// file: core/classic_timer.v
// dual classic counter/timer with avalon-mm register slave
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`include "classic_timer_regs.vh"
module classic_timer (
	input wire mclk_i,
	input wire nrst_i,
	input wire [7:0] address_i,
	input wire read_i,
	input wire write_i,
	input wire [31:0] writedata_i,
	input wire [3:0] byteenable_i,
	output reg [31:0] readdata_o,
	output wire waitrequest_o,
	input wire timer_zero_count_pin_i,
	input wire timer_one_count_pin_i,
	input wire ext_irq_zero_input_i,
	input wire ext_irq_one_input_i,
	input wire ext_clk_i,
	input wire vector_timer_zero_i,
	input wire vector_timer_one_i,
	input wire vector_irq_zero_i,
	input wire vector_irq_one_i,
	output wire timer_zero_irq_o,
	output wire timer_one_irq_o,
	output wire ext_irq_zero_o,
	output wire ext_irq_one_o,
	output reg timer_one_overflow_o
);
	reg [7:0] ctrl_q;
	reg [7:0] mode_q;
	reg [7:0] clksrc_q;
	reg [7:0] irqcfg_q;
	reg [7:0] t0_lo_q;
	reg [7:0] t0_hi_q;
	reg [7:0] t1_lo_q;
	reg [7:0] t1_hi_q;
	reg ack_q;
	reg [5:0] pre_cnt_q;
	reg [2:0] ext_cnt_q;
	reg pre_tick;
	wire wr_en;
	wire rd_en;
	wire [1:0] sca;
	wire [1:0] m0;
	wire [1:0] m1;
	wire split;
	wire ext_rise;
	wire t0_fall;
	wire t1_fall;
	wire g0_act;
	wire g1_act;
	wire g0_edge;
	wire g1_edge;
	wire g0_lvl;
	wire g1_lvl;
	wire g0_rise;
	wire g0_fall;
	wire g1_rise;
	wire g1_fall;
	wire t0_clk_tick;
	wire t1_clk_tick;
	wire t0_inc;
	wire t1_inc;
	wire th0_inc;
	reg [7:0] t0_lo_d;
	reg [7:0] t0_hi_d;
	reg [7:0] t1_lo_d;
	reg [7:0] t1_hi_d;
	reg t0_ovf;
	reg t1_ovf;
	reg th0_ovf;

	// one wait state per access; answered in the second cycle of the request
	assign wr_en = write_i & ack_q & byteenable_i[0];
	assign rd_en = read_i & ~ack_q;
	assign waitrequest_o = (read_i | write_i) & ~ack_q;

	assign sca = clksrc_q[`CLK_SCA_HI:`CLK_SCA_LO];
	assign m0 = mode_q[`MODE_T0_M_HI:`MODE_T0_M_LO];
	assign m1 = mode_q[`MODE_T1_M_HI:`MODE_T1_M_LO];
	assign split = (m0 == `M_SPLIT);

	// external clock: synchronised, rising edges feed the divide-by-eight count
	edge_sync #(
		.RST_LVL(1'b0)
	) ext_clk_sync (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.pin_i(ext_clk_i),
		.level_o(),
		.fall_o(),
		.rise_o(ext_rise)
	);

	// prescaler: sysclk divided by 12, 4 or 48, or synced external divided by 8
	always @* begin
		case (sca)
			`SCA_EXT8: pre_tick = ext_rise && (ext_cnt_q == `EXT8_LAST);
			`SCA_DIV4: pre_tick = (pre_cnt_q >= `DIV4_LAST);
			`SCA_DIV48: pre_tick = (pre_cnt_q >= `DIV48_LAST);
			`SCA_DIV12: pre_tick = (pre_cnt_q >= `DIV12_LAST);
			default: pre_tick = 1'b0;
		endcase
	end

	// timer zero count pin; idles high, so history resets high
	edge_sync #(
		.RST_LVL(1'b1)
	) t0_pin_sync (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.pin_i(timer_zero_count_pin_i),
		.level_o(),
		.fall_o(t0_fall),
		.rise_o()
	);

	// timer one count pin; idles high, so history resets high
	edge_sync #(
		.RST_LVL(1'b1)
	) t1_pin_sync (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.pin_i(timer_one_count_pin_i),
		.level_o(),
		.fall_o(t1_fall),
		.rise_o()
	);

	// gate and external irq input zero
	edge_sync #(
		.RST_LVL(1'b0)
	) g0_sync (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.pin_i(ext_irq_zero_input_i),
		.level_o(g0_lvl),
		.fall_o(g0_fall),
		.rise_o(g0_rise)
	);

	// gate and external irq input one
	edge_sync #(
		.RST_LVL(1'b0)
	) g1_sync (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.pin_i(ext_irq_one_input_i),
		.level_o(g1_lvl),
		.fall_o(g1_fall),
		.rise_o(g1_rise)
	);

	// gate level and active-going edge judged against the polarity bit
	assign g0_act = (g0_lvl == irqcfg_q[`CFG_POL0]);
	assign g1_act = (g1_lvl == irqcfg_q[`CFG_POL1]);
	assign g0_edge = irqcfg_q[`CFG_POL0] ? g0_rise : g0_fall;
	assign g1_edge = irqcfg_q[`CFG_POL1] ? g1_rise : g1_fall;

	// timer clock choice when not counting pin edges
	assign t0_clk_tick = clksrc_q[`CLK_T0M] ? 1'b1 : pre_tick;
	assign t1_clk_tick = clksrc_q[`CLK_T1M] ? 1'b1 : pre_tick;

	// run enables; timer one ignores its run bit and pin while zero is split
	assign t0_inc = ctrl_q[`CTRL_TR0] & (~mode_q[`MODE_T0_GATE] | g0_act) &
		(mode_q[`MODE_T0_CT] ? t0_fall : t0_clk_tick);
	assign th0_inc = split & ctrl_q[`CTRL_TR1] & t0_clk_tick;
	assign t1_inc = (m1 != `M_SPLIT) & (split ? t1_clk_tick :
		(ctrl_q[`CTRL_TR1] & (~mode_q[`MODE_T1_GATE] | g1_act) &
		(mode_q[`MODE_T1_CT] ? t1_fall : t1_clk_tick)));

	// timer zero counting per mode
	always @* begin
		t0_lo_d = t0_lo_q;
		t0_hi_d = t0_hi_q;
		t0_ovf = 1'b0;
		th0_ovf = 1'b0;
		if (t0_inc) begin
			case (m0)
				`M_13BIT: begin
					t0_lo_d = {`HI_BITS_KEEP, t0_lo_q[4:0] + 5'd1};
					if (t0_lo_q[4:0] == `LO5_MAX) begin
						t0_hi_d = t0_hi_q + 8'd1;
						t0_ovf = (t0_hi_q == `BYTE_MAX);
					end
				end
				`M_16BIT: begin
					t0_lo_d = t0_lo_q + 8'd1;
					if (t0_lo_q == `BYTE_MAX) begin
						t0_hi_d = t0_hi_q + 8'd1;
						t0_ovf = (t0_hi_q == `BYTE_MAX);
					end
				end
				`M_RELOAD: begin
					t0_lo_d = (t0_lo_q == `BYTE_MAX) ? t0_hi_q : t0_lo_q + 8'd1;
					t0_ovf = (t0_lo_q == `BYTE_MAX);
				end
				default: begin
					t0_lo_d = t0_lo_q + 8'd1;
					t0_ovf = (t0_lo_q == `BYTE_MAX);
				end
			endcase
		end
		if (th0_inc) begin
			t0_hi_d = t0_hi_q + 8'd1;
			th0_ovf = (t0_hi_q == `BYTE_MAX);
		end
	end

	// timer one counting, same first three modes as timer zero; mode three holds it
	always @* begin
		t1_lo_d = t1_lo_q;
		t1_hi_d = t1_hi_q;
		t1_ovf = 1'b0;
		if (t1_inc) begin
			case (m1)
				`M_13BIT: begin
					t1_lo_d = {`HI_BITS_KEEP, t1_lo_q[4:0] + 5'd1};
					if (t1_lo_q[4:0] == `LO5_MAX) begin
						t1_hi_d = t1_hi_q + 8'd1;
						t1_ovf = (t1_hi_q == `BYTE_MAX);
					end
				end
				`M_16BIT: begin
					t1_lo_d = t1_lo_q + 8'd1;
					if (t1_lo_q == `BYTE_MAX) begin
						t1_hi_d = t1_hi_q + 8'd1;
						t1_ovf = (t1_hi_q == `BYTE_MAX);
					end
				end
				`M_RELOAD: begin
					t1_lo_d = (t1_lo_q == `BYTE_MAX) ? t1_hi_q : t1_lo_q + 8'd1;
					t1_ovf = (t1_lo_q == `BYTE_MAX);
				end
				default: begin
					t1_ovf = 1'b0;
				end
			endcase
		end
	end

	// system clock prescaler, held at zero while the external source is chosen
	always @(posedge mclk_i) begin
		if (!nrst_i)
			pre_cnt_q <= `CNT_ZERO6;
		else if (sca == `SCA_EXT8 || pre_tick)
			pre_cnt_q <= `CNT_ZERO6;
		else
			pre_cnt_q <= pre_cnt_q + 6'd1;
	end

	// external clock rising edges, wrapping every eighth
	always @(posedge mclk_i) begin
		if (!nrst_i)
			ext_cnt_q <= `CNT_ZERO3;
		else if (ext_rise)
			ext_cnt_q <= ext_cnt_q + 3'd1;
	end

	// bus answer: high in the second cycle of every request
	always @(posedge mclk_i) begin
		if (!nrst_i)
			ack_q <= 1'b0;
		else
			ack_q <= (read_i | write_i) & ~ack_q;
	end

	// registers: software writes, hardware counts, flags with set over clear
	always @(posedge mclk_i) begin
		if (!nrst_i) begin
			ctrl_q <= `RESET_BYTE;
			mode_q <= `RESET_BYTE;
			clksrc_q <= `RESET_BYTE;
			irqcfg_q <= `RESET_BYTE;
			t0_lo_q <= `RESET_BYTE;
			t0_hi_q <= `RESET_BYTE;
			t1_lo_q <= `RESET_BYTE;
			t1_hi_q <= `RESET_BYTE;
			timer_one_overflow_o <= 1'b0;
		end else begin
			t0_lo_q <= t0_lo_d;
			t0_hi_q <= t0_hi_d;
			t1_lo_q <= t1_lo_d;
			t1_hi_q <= t1_hi_d;
			timer_one_overflow_o <= t1_ovf;
			if (wr_en) begin
				case (address_i)
					`ADDR_CTRL: ctrl_q <= writedata_i[7:0];
					`ADDR_MODE: mode_q <= writedata_i[7:0];
					`ADDR_CLKSRC: clksrc_q <= writedata_i[7:0];
					`ADDR_IRQCFG: irqcfg_q <= writedata_i[7:0];
					`ADDR_T0_LO: t0_lo_q <= writedata_i[7:0];
					`ADDR_T0_HI: t0_hi_q <= writedata_i[7:0];
					`ADDR_T1_LO: t1_lo_q <= writedata_i[7:0];
					`ADDR_T1_HI: t1_hi_q <= writedata_i[7:0];
					default: ctrl_q <= ctrl_q;
				endcase
			end
			// vectoring clears overflow and edge irq flags
			if (vector_timer_zero_i)
				ctrl_q[`CTRL_TF0] <= 1'b0;
			if (vector_timer_one_i)
				ctrl_q[`CTRL_TF1] <= 1'b0;
			if (vector_irq_zero_i && ctrl_q[`CTRL_IT0])
				ctrl_q[`CTRL_IE0] <= 1'b0;
			if (vector_irq_one_i && ctrl_q[`CTRL_IT1])
				ctrl_q[`CTRL_IE1] <= 1'b0;
			// hardware sets win over any clear in the same cycle
			if (t0_ovf)
				ctrl_q[`CTRL_TF0] <= 1'b1;
			if (th0_ovf || (t1_ovf && !split))
				ctrl_q[`CTRL_TF1] <= 1'b1;
			if (ctrl_q[`CTRL_IT0] ? g0_edge : 1'b1)
				ctrl_q[`CTRL_IE0] <= ctrl_q[`CTRL_IT0] | g0_act;
			if (ctrl_q[`CTRL_IT1] ? g1_edge : 1'b1)
				ctrl_q[`CTRL_IE1] <= ctrl_q[`CTRL_IT1] | g1_act;
		end
	end

	// read data captured on the wait-state cycle, held at the answer edge
	always @(posedge mclk_i) begin
		if (!nrst_i) begin
			readdata_o <= 32'h00000000;
		end else if (rd_en) begin
			case (address_i)
				`ADDR_CTRL: readdata_o <= {24'h000000, ctrl_q};
				`ADDR_MODE: readdata_o <= {24'h000000, mode_q};
				`ADDR_CLKSRC: readdata_o <= {24'h000000, clksrc_q};
				`ADDR_IRQCFG: readdata_o <= {24'h000000, irqcfg_q};
				`ADDR_T0_LO: readdata_o <= {24'h000000, t0_lo_q};
				`ADDR_T0_HI: readdata_o <= {24'h000000, t0_hi_q};
				`ADDR_T1_LO: readdata_o <= {24'h000000, t1_lo_q};
				`ADDR_T1_HI: readdata_o <= {24'h000000, t1_hi_q};
				default: readdata_o <= 32'h00000000;
			endcase
		end
	end

	assign timer_zero_irq_o = ctrl_q[`CTRL_TF0];
	assign timer_one_irq_o = ctrl_q[`CTRL_TF1];
	assign ext_irq_zero_o = ctrl_q[`CTRL_IE0];
	assign ext_irq_one_o = ctrl_q[`CTRL_IE1];
endmodule // classic_timer

// two-flop synchroniser with one stage of history for edge detection
module edge_sync #(
	parameter RST_LVL = 1'b0
) (
	input wire mclk_i,
	input wire nrst_i,
	input wire pin_i,
	output wire level_o,
	output wire fall_o,
	output wire rise_o
);
	reg meta_q;
	reg sync_q;
	reg prev_q;

	// all stages reset to the pin's idle level so no false edge follows reset
	always @(posedge mclk_i) begin
		if (!nrst_i) begin
			meta_q <= RST_LVL;
			sync_q <= RST_LVL;
			prev_q <= RST_LVL;
		end else begin
			meta_q <= pin_i;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// only the second stage and its history are read; the first may be metastable
	assign level_o = sync_q;
	assign fall_o = prev_q & ~sync_q;
	assign rise_o = sync_q & ~prev_q;
endmodule // edge_sync

// file: core/classic_timer_regs.vh
// register map, field positions and constants for the dual classic counter/timer
`ifndef CLASSIC_TIMER_REGS_VH
`define CLASSIC_TIMER_REGS_VH
`define ADDR_CTRL 8'h88
`define ADDR_MODE 8'h89
`define ADDR_T0_LO 8'h8A
`define ADDR_T1_LO 8'h8B
`define ADDR_T0_HI 8'h8C
`define ADDR_T1_HI 8'h8D
`define ADDR_CLKSRC 8'h8E
`define ADDR_IRQCFG 8'h8F
`define CTRL_TF1 7
`define CTRL_TR1 6
`define CTRL_TF0 5
`define CTRL_TR0 4
`define CTRL_IE1 3
`define CTRL_IT1 2
`define CTRL_IE0 1
`define CTRL_IT0 0
`define MODE_T1_GATE 7
`define MODE_T1_CT 6
`define MODE_T1_M_HI 5
`define MODE_T1_M_LO 4
`define MODE_T0_GATE 3
`define MODE_T0_CT 2
`define MODE_T0_M_HI 1
`define MODE_T0_M_LO 0
`define CLK_T1M 3
`define CLK_T0M 2
`define CLK_SCA_HI 1
`define CLK_SCA_LO 0
`define CFG_POL1 1
`define CFG_POL0 0
`define RESET_BYTE 8'h00
`define M_13BIT 2'b00
`define M_16BIT 2'b01
`define M_RELOAD 2'b10
`define M_SPLIT 2'b11
`define SCA_DIV12 2'b00
`define SCA_DIV4 2'b01
`define SCA_DIV48 2'b10
`define SCA_EXT8 2'b11
`define DIV12_LAST 6'd11
`define DIV4_LAST 6'd3
`define DIV48_LAST 6'd47
`define EXT8_LAST 3'd7
`define CNT_ZERO6 6'd0
`define CNT_ZERO3 3'd0
`define LO5_MAX 5'h1F
`define BYTE_MAX 8'hFF
`define HI_BITS_KEEP 3'h0
`endif

// file: verification/classic_timer_sva.sv
// port assertions for the classic timer
`timescale 1ns/1ps
module classic_timer_sva (
	input wire mclk_i,
	input wire nrst_i,
	input wire [7:0] address_i,
	input wire read_i,
	input wire write_i,
	input wire [31:0] writedata_i,
	input wire [3:0] byteenable_i,
	input wire [31:0] readdata_o,
	input wire waitrequest_o,
	input wire ext_irq_zero_input_i,
	input wire ext_irq_one_input_i,
	input wire vector_irq_zero_i,
	input wire ext_irq_zero_o,
	input wire timer_one_irq_o,
	input wire timer_one_overflow_o
);
	reg [7:0] md_q, ct_q, cf_q;
	wire rq_w = read_i || write_i;
	wire wr_w = write_i && !waitrequest_o && byteenable_i[0];
	wire on_w = ext_irq_zero_input_i == cf_q[0];
	wire off_w = md_q[7] && md_q[1:0] != 2'b11 && ext_irq_one_input_i != cf_q[1];
	// shadow of the bits that only software changes
	always @(posedge mclk_i) begin
		if (!nrst_i) begin
			md_q <= 8'h00;
			ct_q <= 8'h00;
			cf_q <= 8'h00;
		end else if (wr_w && address_i == 8'h89) begin
			md_q <= writedata_i[7:0];
		end else if (wr_w && address_i == 8'h88) begin
			ct_q <= writedata_i[7:0];
		end else if (wr_w && address_i == 8'h8F) begin
			cf_q <= writedata_i[7:0];
		end
	end
	default clocking dc @(posedge mclk_i);
	endclocking
	default disable iff (!nrst_i);
	wait_one_a: assert property (rq_w && waitrequest_o |=> !waitrequest_o)
		else $error("long wait");
	rd_hole_a: assert property (read_i && !waitrequest_o && address_i[7:3] != 5'h11
		|-> readdata_o == 32'h0) else $error("hole read");
	lvl_set_a: assert property ((!ct_q[0] && on_w)[*5] |-> ext_irq_zero_o)
		else $error("level flag low");
	lvl_clr_a: assert property ((!ct_q[0] && !on_w && !write_i)[*5] |-> !ext_irq_zero_o)
		else $error("level flag high");
	edge_vec_a: assert property ((ct_q[0] && !write_i && $stable(ext_irq_zero_input_i))[*5]
		##0 vector_irq_zero_i |=> !ext_irq_zero_o) else $error("vector kept flag");
	t1_flag_a: assert property (md_q[1:0] != 2'b11 && $past(md_q[1:0]) != 2'b11
		&& timer_one_overflow_o |-> ##[0:1] timer_one_irq_o) else $error("no flag");
	t1_off_a: assert property (md_q[5:4] == 2'b11 && $past(md_q[5:4], 2) == 2'b11
		|-> !timer_one_overflow_o) else $error("mode three ran");
	gate_hold_a: assert property (off_w[*6] |-> !timer_one_overflow_o)
		else $error("gated timer ran");
	cover property (ext_irq_zero_o);
	cover property (timer_one_overflow_o);
	cover property (read_i && !waitrequest_o);
endmodule // classic_timer_sva
bind classic_timer classic_timer_sva sva_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
	.address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
	.byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
	.ext_irq_zero_input_i(ext_irq_zero_input_i), .ext_irq_one_input_i(ext_irq_one_input_i),
	.vector_irq_zero_i(vector_irq_zero_i), .ext_irq_zero_o(ext_irq_zero_o),
	.timer_one_irq_o(timer_one_irq_o), .timer_one_overflow_o(timer_one_overflow_o));

// file: verification/pin_model.sv
// external count pins and oscillator seen by the timer
`timescale 1ns/1ps
module pin_model (
	input wire mclk_i,
	output reg [1:0] cnt_o,
	output wire xclk_o
);
	reg [1:0] ph_q;
	// pins idle high, oscillator at a quarter of the clock
	initial begin
		cnt_o = 2'b11;
		ph_q = 2'b00;
	end
	always @(posedge mclk_i) begin
		ph_q <= ph_q + 2'b01;
	end
	assign xclk_o = ph_q[1];
	// falling edges on one pin, each level held two clocks
	task fall(input integer p, input integer n);
		integer k;
		for (k = 0; k < n; k = k + 1) begin
			repeat (2) @(posedge mclk_i);
			cnt_o[p] <= 1'b0;
			repeat (2) @(posedge mclk_i);
			cnt_o[p] <= 1'b1;
		end
	endtask
endmodule // pin_model

// file: verification/tb_classic_timer.sv
// self-checking bench for the dual classic counter/timer
`timescale 1ns/1ps
module tb_classic_timer;
	reg mclk_i, nrst_i, read_i, write_i, g0, vt0, vi0;
	reg [3:0] be;
	reg [7:0] address_i;
	reg [31:0] writedata_i;
	wire [31:0] readdata_o;
	wire waitrequest_o, tz, t1f, ez, eo, ov, xclk;
	wire [1:0] cnt;
	integer err_total, cmp_count, seed, v, i;
	reg [7:0] exp_q[$];
	reg [7:0] msk_q[$];
	pin_model pm (.mclk_i(mclk_i), .cnt_o(cnt), .xclk_o(xclk));
	classic_timer uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .address_i(address_i),
		.read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(be),
		.readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
		.timer_zero_count_pin_i(cnt[0]), .timer_one_count_pin_i(cnt[1]),
		.ext_irq_zero_input_i(g0), .ext_irq_one_input_i(1'b0), .ext_clk_i(xclk),
		.vector_timer_zero_i(vt0), .vector_timer_one_i(1'b0), .vector_irq_zero_i(vi0),
		.vector_irq_one_i(1'b0), .timer_zero_irq_o(tz), .timer_one_irq_o(t1f),
		.ext_irq_zero_o(ez), .ext_irq_one_o(eo), .timer_one_overflow_o(ov));
	// system clock
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	task test_done;
		begin
			$display("%0d checks, %0d mismatches", cmp_count, err_total);
			if (err_total == 0 && cmp_count > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] e);
		begin
			cmp_count = cmp_count + 1;
			if (got !== e) begin
				err_total = err_total + 1;
				$display("CHECK FAILED at %0t: got %h want %h", $time, got, e);
			end
		end
	endtask
	// one bus cycle, held until the rising edge that sees waitrequest low
	task bus(input w, input [7:0] a, input [7:0] d, input [7:0] m);
		integer n;
		begin
			@(posedge mclk_i);
			address_i <= a;
			writedata_i <= {24'h0, d};
			read_i <= !w;
			write_i <= w;
			if (!w) begin
				exp_q.push_back(d);
				msk_q.push_back(m);
			end
			n = 0;
			@(posedge mclk_i);
			while (waitrequest_o !== 1'b0) begin
				n = n + 1;
				if (n > 20) begin
					err_total = err_total + 1;
					test_done;
				end
				@(posedge mclk_i);
			end
			read_i <= 1'b0;
			write_i <= 1'b0;
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		bus(1'b1, a, d, 8'h00);
	endtask
	task rd(input [7:0] a, input [7:0] e, input [7:0] m);
		bus(1'b0, a, e, m);
	endtask
	// each completed read takes the oldest note
	always @(posedge mclk_i) begin
		if (read_i === 1'b1 && waitrequest_o === 1'b0) begin
			chk(readdata_o & {24'hFFFFFF, msk_q[0]}, {24'h0, exp_q[0] & msk_q[0]});
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end
	initial begin
		{nrst_i, read_i, write_i, g0, vt0, vi0} = 6'h00;
		be = 4'hF;
		address_i = 8'h00;
		writedata_i = 32'h0;
		err_total = 0;
		cmp_count = 0;
		seed = 27;
		repeat (6) @(posedge mclk_i);
		nrst_i <= 1'b1;
		rd(8'h88, 8'h0A, 8'hFF);
		@(negedge mclk_i);
		chk(eo, 1'b1);
		rd(8'h80, 8'h00, 8'hFF);
		v = $random(seed);
		wr(8'h89, v[7:0]);
		rd(8'h89, v[7:0], 8'hFF);
		$display("map done");
		wr(8'h89, 8'h09);
		wr(8'h8E, 8'h04);
		wr(8'h8F, 8'h03);
		wr(8'h8A, 8'hFE);
		wr(8'h8C, 8'hFF);
		wr(8'h88, 8'h10);
		repeat (10) @(posedge mclk_i);
		rd(8'h8A, 8'hFE, 8'hFF);
		g0 <= 1'b1;
		repeat (10) @(posedge mclk_i);
		rd(8'h88, 8'h22, 8'h22);
		@(negedge mclk_i);
		chk(tz, 1'b1);
		@(posedge mclk_i);
		g0 <= 1'b0;
		repeat (6) @(posedge mclk_i);
		@(negedge mclk_i);
		chk(eo, 1'b0);
		wr(8'h88, 8'h01);
		repeat (6) @(posedge mclk_i);
		rd(8'h88, 8'h01, 8'hFF);
		g0 <= 1'b1;
		repeat (6) @(posedge mclk_i);
		g0 <= 1'b0;
		repeat (6) @(posedge mclk_i);
		@(negedge mclk_i);
		chk(ez, 1'b1);
		@(posedge mclk_i);
		vi0 <= 1'b1;
		@(posedge mclk_i);
		vi0 <= 1'b0;
		@(negedge mclk_i);
		chk(ez, 1'b0);
		$display("gate and irq done");
		wr(8'h89, 8'h00);
		for (i = 0; i < 4; i = i + 1) begin
			wr(8'h8E, {6'h00, i[1:0] + 2'h3});
			wr(8'h8C, 8'hFF);
			wr(8'h8A, 8'hFE);
			wr(8'h88, 8'h10);
			repeat (200) @(posedge mclk_i);
			rd(8'h88, 8'h20, 8'h20);
			wr(8'h88, 8'h00);
		end
		rd(8'h8C, 8'h00, 8'hFF);
		rd(8'h8A, 8'h00, 8'h1C);
		wr(8'h89, 8'h06);
		wr(8'h8C, 8'hFD);
		wr(8'h8A, 8'hFE);
		wr(8'h88, 8'h10);
		pm.fall(0, 2);
		repeat (6) @(posedge mclk_i);
		rd(8'h8A, 8'hFD, 8'hFF);
		rd(8'h88, 8'h30, 8'hFF);
		vt0 <= 1'b1;
		@(posedge mclk_i);
		vt0 <= 1'b0;
		@(negedge mclk_i);
		chk(tz, 1'b0);
		$display("count modes done");
		wr(8'h88, 8'h00);
		wr(8'h8F, 8'h03);
		wr(8'h89, 8'hA0);
		wr(8'h8E, 8'h08);
		wr(8'h8D, 8'hF0);
		wr(8'h8B, 8'hF0);
		wr(8'h88, 8'h40);
		repeat (20) @(posedge mclk_i);
		rd(8'h8B, 8'hF0, 8'hFF);
		wr(8'h89, 8'h20);
		repeat (20) @(posedge mclk_i);
		rd(8'h88, 8'hC0, 8'hC0);
		wr(8'h88, 8'h00);
		wr(8'h88, 8'h00);
		wr(8'h89, 8'h03);
		wr(8'h8E, 8'h0C);
		wr(8'h8A, 8'h40);
		wr(8'h8C, 8'hFE);
		wr(8'h88, 8'h40);
		repeat (10) @(posedge mclk_i);
		rd(8'h8A, 8'h40, 8'hFF);
		rd(8'h88, 8'hC0, 8'hF0);
		wr(8'h89, 8'h33);
		repeat (20) @(posedge mclk_i);
		$display("timer one and split done");
		test_done;
	end
endmodule // tb_classic_timer
